// file: shared/pmr_pkg.sv
/*
 * Shared constants for the power mode and reset controller: register
 * offsets, bit positions, reset source indices, reset values and timing.
 * Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package pmr_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 10000;
    localparam int RST_HOLD_US = 10;
    // least time, so the cycle count rounds up
    localparam int RST_HOLD_CYC = (RST_HOLD_US * CLK_FREQ_KHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] PCTRL0_OFS = 8'h00;
    localparam logic [ADR_W-1:0] PCTRL1_OFS = 8'h04;
    localparam logic [ADR_W-1:0] REGCTL_OFS = 8'h08;
    localparam logic [ADR_W-1:0] RSTCTL_OFS = 8'h0c;
    localparam logic [ADR_W-1:0] RSTSRC_OFS = 8'h10;
    localparam logic [ADR_W-1:0] MODESTAT_OFS = 8'h14;

    // field positions
    localparam int IDLE_BIT = 0;
    localparam int STOP_BIT = 1;
    localparam int SUSPEND_BIT = 0;
    localparam int SNOOZE_BIT = 1;
    localparam int REGULATOR_STOP_CONFIG_BIT_BIT = 0;
    localparam int SWRST_BIT = 0;
    localparam int RETAIN_BIT = 1;
    localparam int INRESET_BIT = 7;

    // ------------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------------
    localparam int NUM_SRC = 8;
    localparam int SRC_POR = 0;
    localparam int SRC_PIN = 1;
    localparam int SRC_CMP = 2;
    localparam int SRC_SW = 3;
    localparam int SRC_SUPPLY = 4;
    localparam int SRC_WDOG = 5;
    localparam int SRC_MCLK = 6;
    localparam int SRC_FLASH = 7;
    localparam logic [NUM_SRC-1:0] PIN_ONLY_MASK = 8'h02;
    localparam logic [NUM_SRC-1:0] RSTSRC_RESET = 8'h01;

    localparam logic [15:0] FETCH_START = 16'h0000;

    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_IDLE,
        MODE_SUSPEND,
        MODE_SNOOZE,
        MODE_STOP,
        MODE_SHUTDOWN
    } mode_e;

endpackage

// file: rtl/fall_detect.sv
/*
 * Falling edge detector: one-cycle pulse when a level goes from 1 to 0.
 * Assumes the input is synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module fall_detect #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] fall
);
    logic [W-1:0] prev;

    if (W < 1) begin
        $error("fall_detect: W must be at least 1");
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prev <= RST_VAL;
        end else begin
            prev <= din;
        end
    end

    assign fall = prev & ~din;
endmodule
`default_nettype wire

// file: rtl/hold_counter.sv
/*
 * Retriggerable hold counter: busy for CYCLES cycles after the last
 * trigger, and busy from asynchronous reset onward.
 * Assumes trig is synchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module hold_counter #(
    parameter int CYCLES = 100
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic trig,
    output logic busy
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    logic [CW-1:0] count;

    if (CYCLES < 1) begin
        $error("hold_counter: CYCLES must be at least 1");
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= LOAD;
        end else if (trig) begin
            count <= LOAD;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    assign busy = (count != '0);
endmodule
`default_nettype wire

// file: rtl/power_mode_reset_control.sv
/*
 * Power mode and reset controller: power mode state machine, clock,
 * oscillator and regulator controls, reset source collection and the
 * reset hold sequence, behind a classic Wishbone register slave.
 * Assumes all inputs are synchronous to sys_clk and arst_n is power-on.
 */
`timescale 1ns/1ps
`default_nettype none

module power_mode_reset_control #(
    parameter int HOLD_CYCLES = pmr_pkg::RST_HOLD_CYC
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [pmr_pkg::ADR_W-1:0] adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic irqAny,
    input wire logic timer4Event,
    input wire logic spiActivity,
    input wire logic i2cSlaveActivity,
    input wire logic portMatch,
    input wire logic cmp0Out,
    input wire logic configLogicUnitIrq,
    input wire logic sysClkOnOscA,
    input wire logic resetPinNIn,
    input wire logic cmpResetReq,
    input wire logic supplyMonReset,
    input wire logic watchdogReset,
    input wire logic missingClkReset,
    input wire logic flashErrReset,
    output logic resetPinNOut,
    output logic resetPinNOe,
    output logic coreHalt,
    output logic coreReset,
    output logic fetchStart,
    output logic [15:0] fetchAddr,
    output logic watchdogEn,
    output logic sysClkInternal,
    output logic irqDisable,
    output logic timerDisable,
    output logic ramHold,
    output logic coreClkEn,
    output logic periphClkEn,
    output logic highFreqOscAEn,
    output logic highFreqOscBEn,
    output logic regLowBias,
    output logic lowFreqTimerEn,
    output logic powerNetsOn,
    output logic pinHold,
    output logic portDefault,
    output logic analogRetain
);
    import pmr_pkg::*;

    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 4096) begin
        $error("power_mode_reset_control: HOLD_CYCLES out of range");
    end

    mode_e mode;
    mode_e next_mode;
    logic inReset;
    logic holdBusy;
    logic anyReset;
    logic leaveReset;
    logic cmp0Fall;
    logic wakeAny;
    logic wake;
    logic pinDrive;
    logic [NUM_SRC-1:0] srcVec;
    logic [NUM_SRC-1:0] activeSrc;
    logic [NUM_SRC-1:0] rstCause;
    logic idleReq;
    logic stopReq;
    logic suspendReq;
    logic snoozeReq;
    logic stopCfg;
    logic retain;
    logic swReq;
    logic busReq;
    logic wrStrobe;
    logic [31:0] rdData;

    // ------------------------------------------------------------------
    // reset sources and hold sequence
    // ------------------------------------------------------------------
    always_comb begin
        srcVec = '0;
        // our own pin drive must not re-trigger the pin source
        srcVec[SRC_PIN] = !resetPinNIn && !resetPinNOe;
        srcVec[SRC_CMP] = cmpResetReq;
        srcVec[SRC_SW] = swReq;
        srcVec[SRC_SUPPLY] = supplyMonReset;
        srcVec[SRC_WDOG] = watchdogReset;
        srcVec[SRC_MCLK] = missingClkReset;
        srcVec[SRC_FLASH] = flashErrReset;
        // shutdown: internal sources are unpowered, only the pin counts
        activeSrc = (mode == MODE_SHUTDOWN) ? (srcVec & PIN_ONLY_MASK) : srcVec;
    end

    assign anyReset = |activeSrc;

    hold_counter #(
        .CYCLES(HOLD_CYCLES)
    ) u_hold (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .trig(anyReset),
        .busy(holdBusy)
    );

    fall_detect #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_leave (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .din(inReset),
        .fall(leaveReset)
    );

    fall_detect #(
        .W(1),
        .RST_VAL(1'b0)
    ) u_cmp0 (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .din(cmp0Out),
        .fall(cmp0Fall)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            inReset <= 1'b1;
        end else begin
            inReset <= anyReset | holdBusy;
        end
    end

    // cause of the last reset; each new reset replaces it, power-on loads the POR bit
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rstCause <= RSTSRC_RESET;
        end else if (anyReset && !inReset) begin
            rstCause <= activeSrc;
        end
    end

    // power-on starts with the pin driven; supply resets drive it too
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinDrive <= 1'b1;
        end else if (anyReset && !inReset) begin
            pinDrive <= activeSrc[SRC_SUPPLY];
        end else if (!inReset) begin
            pinDrive <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // power mode state machine
    // ------------------------------------------------------------------
    assign wakeAny = timer4Event | spiActivity | i2cSlaveActivity | portMatch
                     | cmp0Fall | configLogicUnitIrq;

    always_comb begin
        next_mode = mode;
        unique case (mode)
            MODE_NORMAL: begin
                if (stopReq) begin
                    next_mode = stopCfg ? MODE_SHUTDOWN : MODE_STOP;
                end else if (snoozeReq && sysClkOnOscA) begin
                    next_mode = MODE_SNOOZE;
                end else if (suspendReq && sysClkOnOscA) begin
                    next_mode = MODE_SUSPEND;
                end else if (idleReq) begin
                    next_mode = MODE_IDLE;
                end
            end
            MODE_IDLE: begin
                if (irqAny) begin
                    next_mode = MODE_NORMAL;
                end
            end
            MODE_SUSPEND, MODE_SNOOZE: begin
                if (wakeAny) begin
                    next_mode = MODE_NORMAL;
                end
            end
            MODE_STOP, MODE_SHUTDOWN: begin
                next_mode = mode;
            end
            default: begin
                next_mode = MODE_NORMAL;
            end
        endcase
        if (inReset || anyReset) begin
            next_mode = MODE_NORMAL;
        end
    end

    assign wake = (mode != MODE_NORMAL) && (next_mode == MODE_NORMAL)
                  && !inReset && !anyReset;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode <= MODE_NORMAL;
        end else begin
            mode <= next_mode;
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    assign busReq = cyc_i && stb_i && !ack_o;
    // the core is halted in reset, so writes then are dropped
    assign wrStrobe = busReq && we_i && sel_i[0] && !inReset;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            idleReq <= 1'b0;
            stopReq <= 1'b0;
            suspendReq <= 1'b0;
            snoozeReq <= 1'b0;
            stopCfg <= 1'b0;
        end else if (inReset) begin
            idleReq <= 1'b0;
            stopReq <= 1'b0;
            suspendReq <= 1'b0;
            snoozeReq <= 1'b0;
            stopCfg <= 1'b0;
        end else begin
            if (wake) begin
                idleReq <= 1'b0;
                suspendReq <= 1'b0;
                snoozeReq <= 1'b0;
            end
            // a write in the wake cycle lands after the clear and wins
            if (wrStrobe && adr_i == PCTRL0_OFS) begin
                idleReq <= dat_i[IDLE_BIT];
                stopReq <= dat_i[STOP_BIT];
            end
            if (wrStrobe && adr_i == PCTRL1_OFS) begin
                suspendReq <= dat_i[SUSPEND_BIT];
                snoozeReq <= dat_i[SNOOZE_BIT];
            end
            if (wrStrobe && adr_i == REGCTL_OFS) begin
                stopCfg <= dat_i[REGULATOR_STOP_CONFIG_BIT_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            swReq <= 1'b0;
        end else begin
            swReq <= wrStrobe && adr_i == RSTCTL_OFS && dat_i[SWRST_BIT];
        end
    end

    // retention survives every reset except power-on
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            retain <= 1'b0;
        end else if (wrStrobe && adr_i == RSTCTL_OFS) begin
            retain <= dat_i[RETAIN_BIT];
        end
    end

    // ------------------------------------------------------------------
    // bus slave: ack one cycle after the request, unmapped reads zero
    // ------------------------------------------------------------------
    always_comb begin
        rdData = '0;
        unique case (adr_i)
            PCTRL0_OFS: begin
                rdData[IDLE_BIT] = idleReq;
                rdData[STOP_BIT] = stopReq;
            end
            PCTRL1_OFS: begin
                rdData[SUSPEND_BIT] = suspendReq;
                rdData[SNOOZE_BIT] = snoozeReq;
            end
            REGCTL_OFS: rdData[REGULATOR_STOP_CONFIG_BIT_BIT] = stopCfg;
            RSTCTL_OFS: rdData[RETAIN_BIT] = retain;
            RSTSRC_OFS: rdData[NUM_SRC-1:0] = rstCause;
            MODESTAT_OFS: begin
                rdData[2:0] = mode;
                rdData[INRESET_BIT] = inReset;
            end
            default: rdData = '0;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_o <= 1'b0;
            dat_o <= '0;
        end else begin
            ack_o <= busReq;
            dat_o <= (busReq && !we_i) ? rdData : '0;
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            coreHalt <= 1'b1;
            coreReset <= 1'b1;
            irqDisable <= 1'b1;
            timerDisable <= 1'b1;
            ramHold <= 1'b1;
            fetchStart <= 1'b0;
            fetchAddr <= FETCH_START;
            sysClkInternal <= 1'b0;
        end else begin
            coreHalt <= inReset || mode != MODE_NORMAL;
            coreReset <= inReset;
            irqDisable <= inReset;
            timerDisable <= inReset;
            // RAM has no reset path; writes are only blocked meanwhile
            ramHold <= inReset;
            fetchStart <= leaveReset;
            fetchAddr <= FETCH_START;
            sysClkInternal <= leaveReset;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            watchdogEn <= 1'b0;
        end else if (leaveReset) begin
            watchdogEn <= 1'b1;
        end else if (inReset) begin
            watchdogEn <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            coreClkEn <= 1'b1;
            periphClkEn <= 1'b1;
            highFreqOscAEn <= 1'b1;
            highFreqOscBEn <= 1'b1;
            regLowBias <= 1'b0;
            lowFreqTimerEn <= 1'b0;
            powerNetsOn <= 1'b1;
            pinHold <= 1'b0;
        end else begin
            coreClkEn <= mode == MODE_NORMAL;
            periphClkEn <= mode == MODE_NORMAL || mode == MODE_IDLE;
            highFreqOscAEn <= mode == MODE_NORMAL || mode == MODE_IDLE;
            highFreqOscBEn <= mode == MODE_NORMAL || mode == MODE_IDLE;
            regLowBias <= mode == MODE_SNOOZE;
            lowFreqTimerEn <= mode == MODE_SUSPEND || mode == MODE_SNOOZE;
            powerNetsOn <= !(mode == MODE_STOP || mode == MODE_SHUTDOWN);
            pinHold <= mode == MODE_STOP || mode == MODE_SHUTDOWN;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            portDefault <= 1'b1;
            analogRetain <= 1'b0;
            resetPinNOut <= 1'b0;
            resetPinNOe <= 1'b1;
        end else begin
            portDefault <= inReset && !retain;
            analogRetain <= retain;
            resetPinNOut <= 1'b0;
            resetPinNOe <= inReset && pinDrive;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_sleepWake;
        (mode == MODE_SUSPEND || mode == MODE_SNOOZE) && wakeAny && !anyReset && !inReset;
    endsequence
    sequence s_leave;
        inReset ##1 !inReset;
    endsequence

    a_normal_run: assert property (
        mode == MODE_NORMAL && !inReset |=> coreClkEn && periphClkEn && !coreHalt)
        else $error("normal mode lost a clock");
    a_idle_wake: assert property (
        mode == MODE_IDLE && irqAny && !anyReset |=> mode == MODE_NORMAL ##1 coreClkEn)
        else $error("idle did not wake on interrupt");
    a_suspend_osc: assert property (
        mode == MODE_SUSPEND |=> !highFreqOscAEn && !highFreqOscBEn && !regLowBias
        && !periphClkEn) else $error("suspend outputs wrong");
    a_suspend_clock: assert property (
        $rose(mode == MODE_SUSPEND || mode == MODE_SNOOZE) |-> $past(sysClkOnOscA))
        else $error("sleep entered without oscillator A");
    a_snooze_bias: assert property (
        mode == MODE_SNOOZE |=> regLowBias && !coreClkEn && lowFreqTimerEn)
        else $error("snooze outputs wrong");
    a_sleep_wake: assert property (
        s_sleepWake |=> mode == MODE_NORMAL ##1 highFreqOscAEn && !coreHalt)
        else $error("sleep did not wake");
    a_stop_exit: assert property (
        mode == MODE_STOP && anyReset |=> mode == MODE_NORMAL && inReset ##1 powerNetsOn)
        else $error("stop did not exit on reset");
    a_shutdown_hold: assert property (
        mode == MODE_SHUTDOWN && resetPinNIn |=> mode == MODE_SHUTDOWN && !inReset
        ##1 pinHold && !powerNetsOn) else $error("shutdown left without pin reset");
    a_reset_entry: assert property (
        anyReset |=> inReset ##1 coreHalt && irqDisable && timerDisable && ramHold)
        else $error("reset entry incomplete");
    a_pin_drive: assert property (
        inReset && pinDrive |=> resetPinNOe && !resetPinNOut)
        else $error("reset pin not driven low");
    a_port_state: assert property (
        inReset |=> portDefault == !retain && analogRetain == retain)
        else $error("port default or retention wrong");
    a_leave_fetch: assert property (
        s_leave |=> fetchStart && watchdogEn && !coreReset && fetchAddr == FETCH_START)
        else $error("reset exit sequence wrong");
    a_reset_mode: assert property (
        inReset |=> mode == MODE_NORMAL && !idleReq && !stopReq && !snoozeReq)
        else $error("reset left a mode request");
endmodule
`default_nettype wire

// file: bench/pmr_far_end.sv
/*
 * Far-end model: the reset pin wire with its pull-up and an external switch.
 * Assumes the switch is changed just after rising sys_clk edges.
 */
`timescale 1ns/1ps
`default_nettype none
module pmr_far_end (
    input wire logic resetPinNOut,
    input wire logic resetPinNOe,
    input wire logic pullLow,
    output logic pinLevel
);
    // ------------------------------------------------------------
    // reset pin wire
    // ------------------------------------------------------------
    // pull-up wins when nobody drives, so a released pin reads high
    assign pinLevel = ((resetPinNOe && !resetPinNOut) || pullLow) ? 1'h0 : 1'h1;
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/*
 * Testbench: mode, wake and reset sequences; mode requests go through Wishbone tasks, wake and reset inputs are driven directly.
 * Assumes pmr_pkg and the design; the reset hold is shortened to 4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmr_pkg::*;
    logic sys_clk = '0, arst_n = '0, cyc = '0, stb = '0, we = '0, ack, pinN, pOut, pOe;
    logic [7:0] adr = '0;
    logic [31:0] dat = '0, q, rd;
    logic [3:0] sel = '0;
    logic irq = '0, osc = '0, cmp0 = 1'h1, pinLow = '0, halt, irqD, tmrD, ramH, wdEn;
    logic [4:0] wk = '0, rq = '0;
    logic cClk, pClk, oscA, oscB, lowB, lfT, pwr, pHold, pDef, aRet, cRst, fStart, sysInt;
    logic [15:0] fAddr;
    int cz[5] = '{SRC_WDOG, SRC_SUPPLY, SRC_CMP, SRC_MCLK, SRC_FLASH};
    int nErrors = 0, checked = 0, nFetch = 0;

    power_mode_reset_control #(.HOLD_CYCLES(4)) i_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel),
        .dat_o(q), .ack_o(ack), .irqAny(irq), .timer4Event(wk[0]), .spiActivity(wk[1]),
        .i2cSlaveActivity(wk[2]), .portMatch(wk[3]), .configLogicUnitIrq(wk[4]),
        .cmp0Out(cmp0), .sysClkOnOscA(osc), .resetPinNIn(pinN), .watchdogReset(rq[0]),
        .supplyMonReset(rq[1]), .cmpResetReq(rq[2]), .missingClkReset(rq[3]),
        .flashErrReset(rq[4]), .resetPinNOut(pOut), .resetPinNOe(pOe), .coreHalt(halt),
        .coreReset(cRst), .fetchStart(fStart), .fetchAddr(fAddr), .watchdogEn(wdEn),
        .sysClkInternal(sysInt), .irqDisable(irqD), .timerDisable(tmrD), .ramHold(ramH),
        .coreClkEn(cClk), .periphClkEn(pClk), .highFreqOscAEn(oscA), .highFreqOscBEn(oscB),
        .regLowBias(lowB), .lowFreqTimerEn(lfT), .powerNetsOn(pwr), .pinHold(pHold),
        .portDefault(pDef), .analogRetain(aRet));
    pmr_far_end i_far (.resetPinNOut(pOut), .resetPinNOe(pOe), .pullLow(pinLow),
        .pinLevel(pinN));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        if (nErrors == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            nErrors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // ack and read data are taken at the rising edge, and the request is released there
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hf};
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'h1 && n < 20);
        rd = q;
        {cyc, stb} <= 2'h0;
        if (ack !== 1'h1) begin
            nErrors++;
            tally_and_finish;
        end
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        wb(1'h0, a, '0);
        cmp(nm, e, rd & m);
    endtask
    task automatic waitRun;
        int n;
        n = 0;
        do begin
            wb(1'h0, MODESTAT_OFS, '0);
            n++;
        end while (rd[INRESET_BIT] !== 1'h0 && n < 40);
        if (rd[INRESET_BIT] !== 1'h0) begin
            nErrors++;
            tally_and_finish;
        end
        tick(1);
    endtask
    task automatic hit(input int k);
        @(posedge sys_clk) rq[k] <= 1'h1;
        @(posedge sys_clk) rq[k] <= 1'h0;
        tick(3);
    endtask

    // ------------------------------------------------------------
    // clock and scenarios
    // ------------------------------------------------------------
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // every reset exit gives one fetch pulse together with the internal clock pick
    always @(posedge sys_clk) begin
        if (fStart === 1'h1 && sysInt === 1'h1) nFetch <= nFetch + 1;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'h1;
        waitRun;
        cmp("clocks", 32'hf, {cClk, pClk, oscA, oscB});
        rdc("cause", RSTSRC_OFS, 32'hff, 32'h1);
        wb(1'h1, PCTRL0_OFS, 32'h1);
        tick(3);
        cmp("idleClk", 32'h3, {cClk, pClk, oscA});
        @(posedge sys_clk) irq <= 1'h1;
        @(posedge sys_clk) irq <= 1'h0;
        tick(3);
        cmp("idleWake", 32'h1, cClk);
        wb(1'h1, PCTRL1_OFS, 32'h1);
        tick(4);
        rdc("noOscA", MODESTAT_OFS, 32'h7, 32'h0);
        @(posedge sys_clk) osc <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            wb(1'h1, PCTRL1_OFS, (i % 2) ? 32'h2 : 32'h1);
            tick(4);
            rdc("sleep", MODESTAT_OFS, 32'h7, (i % 2) ? 32'h3 : 32'h2);
            cmp("sleepClk", {30'h0, i % 2 == 1, 1'h1},
                {cClk, pClk, oscA, oscB, lowB, lfT});
            if (i < 5) @(posedge sys_clk) wk[i] <= 1'h1;
            else @(posedge sys_clk) cmp0 <= 1'h0;
            @(posedge sys_clk) {wk, cmp0} <= 6'h01;
            tick(4);
            rdc("wake", MODESTAT_OFS, 32'h7, 32'h0);
        end
        wb(1'h1, REGCTL_OFS, 32'h0);
        wb(1'h1, PCTRL0_OFS, 32'h2);
        tick(3);
        cmp("stop", 32'h1, {pwr, pHold});
        for (int k = 0; k < 5; k++) begin
            hit(k);
            cmp("inReset", {25'h3f, k == 1},
                {halt, irqD, tmrD, ramH, pDef, cRst, pOe});
            waitRun;
            cmp("run", 32'h100000, {wdEn, fAddr, irqD, halt, cRst, pOe});
            rdc("mode", MODESTAT_OFS, 32'h7, 32'h0);
            rdc("cause", RSTSRC_OFS, 32'h1 << cz[k], 32'h1 << cz[k]);
        end
        wb(1'h1, REGCTL_OFS, 32'h1);
        wb(1'h1, PCTRL0_OFS, 32'h2);
        hit(0);
        tick(6);
        rdc("shutdown", MODESTAT_OFS, 32'h87, 32'h5);
        @(posedge sys_clk) pinLow <= 1'h1;
        @(posedge sys_clk) pinLow <= 1'h0;
        waitRun;
        rdc("mode", MODESTAT_OFS, 32'h7, 32'h0);
        rdc("cause", RSTSRC_OFS, 32'h2, 32'h2);
        wb(1'h1, RSTCTL_OFS, 32'h2);
        wb(1'h1, RSTCTL_OFS, 32'h3);
        tick(3);
        cmp("retain", 32'h2, {aRet, pDef});
        waitRun;
        rdc("cause", RSTSRC_OFS, 32'h8, 32'h8);
        cmp("fetches", 32'h8, nFetch);
        tally_and_finish;
    end
endmodule
`default_nettype wire
